// ### hdl/rpd_decoder.sv
/*
 * host packet decoder: parses request frames, runs transponder operations,
 * builds and sends the response frame.
 * assumes rx and tx bytes come from a uart engine on clk, and a transponder
 * engine that answers each tag_req with one tag_done pulse.
 */
`timescale 1ns/1ps
module rpd_decoder #(
    parameter int RX_MAX  = 9,
    parameter int RSP_MAX = 52
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [7:0]      rx_byte,
    input  wire logic            rx_valid,
    output logic      [7:0]      tx_byte_ff,
    output logic                 tx_valid_ff,
    input  wire logic            tx_ready,
    output logic                 tag_req_ff,
    output rpd_pkg::rpd_op_t     tag_op_ff,
    output logic                 tag_addressed_ff,
    output logic      [31:0]     tag_addr_ff,
    output logic      [7:0]      tag_block_ff,
    output logic      [31:0]     tag_wdata_ff,
    input  wire logic            tag_done,
    input  wire logic            tag_err,
    input  wire logic [7:0]      tag_err_code,
    input  wire logic [31:0]     tag_rdata,
    input  wire logic [1:0]      tag_lock,
    input  wire logic [31:0]     tag_uid,
    input  wire logic [7:0]      tag_mfr,
    input  wire logic [15:0]     tag_ver,
    input  wire logic [7:0]      tag_nblk,
    input  wire logic [7:0]      tag_bpb,
    output logic                 loader_go_ff,
    output logic                 misc_strobe_ff,
    output logic      [7:0]      misc_cmd_ff,
    output logic      [7:0]      misc_data_ff,
    output logic                 drop_ff
);
    import rpd_pkg::*;

    localparam int RXW  = $clog2(RX_MAX);
    localparam int RSPW = $clog2(RSP_MAX);

    rpd_state_t  st_ff;
    logic        rx_on_ff;
    logic [15:0] rx_cnt_ff;
    logic [15:0] len_ff;
    logic        node_ok_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  cmd_ff;
    logic [7:0]  chk_lo_ff;
    logic        go_ff;
    logic [7:0]  rxd_ff [RX_MAX];
    logic [7:0]  rsp_ff [RSP_MAX];
    logic [7:0]  rsp_cnt_ff;
    logic [7:0]  rsp_flags_ff;
    logic        bmp_mode_ff;
    logic [7:0]  bmp_ff;
    logic [7:0]  bit_ff;
    logic [15:0] tx_idx_ff;
    logic [15:0] tx_len;
    logic [15:0] rx_off;
    logic [15:0] tx_off;
    logic [7:0]  rx_xor;
    logic [7:0]  tx_xor;
    logic [7:0]  tx_next;
    logic        rx_start;
    logic        rx_take;
    logic        tx_load;
    logic        ads;
    logic        dec_tag;
    rpd_op_t     dec_op;
    logic [7:0]  chunk [9];
    logic [3:0]  chunk_n;

    assign rx_start = rx_valid && !rx_on_ff && st_ff == ST_IDLE && rx_byte == SOF;
    assign rx_take  = rx_valid && rx_on_ff;
    assign rx_off   = rx_cnt_ff - IDX_DATA;
    assign tx_len   = FRAME_OVH + {8'h00, rsp_cnt_ff};
    assign tx_off   = tx_idx_ff - IDX_DATA;
    assign tx_load  = st_ff == ST_TX && tx_idx_ff < tx_len && (!tx_valid_ff || tx_ready);
    // the bitmap read ignores the addressed flag
    assign ads      = flags_ff[FLAG_ADDR_BIT] && cmd_ff != CMD_BITMAP;

    rpd_check_acc u_rx_chk (
        .clk     (clk),
        .rst     (rst),
        .clr     (rx_start),
        .en      (rx_start || (rx_take && (rx_cnt_ff <= IDX_LEN_HI
                                          || rx_cnt_ff + 16'h2 < len_ff))),
        .byte_in (rx_byte),
        .lrc_ff  (rx_xor)
    );

    rpd_check_acc u_tx_chk (
        .clk     (clk),
        .rst     (rst),
        .clr     (tx_load && tx_idx_ff == IDX_SOF),
        .en      (tx_load && tx_idx_ff + 16'h2 < tx_len),
        .byte_in (tx_next),
        .lrc_ff  (tx_xor)
    );

    // request frame capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_on_ff   <= 1'b0;
            rx_cnt_ff  <= 16'h0000;
            len_ff     <= 16'h0000;
            node_ok_ff <= 1'b0;
            flags_ff   <= 8'h00;
            cmd_ff     <= 8'h00;
            chk_lo_ff  <= 8'h00;
            go_ff      <= 1'b0;
            drop_ff    <= 1'b0;
            for (int i = 0; i < RX_MAX; i++) rxd_ff[i] <= 8'h00;
        end else begin
            go_ff   <= 1'b0;
            drop_ff <= 1'b0;
            if (rx_start) begin
                rx_on_ff   <= 1'b1;
                rx_cnt_ff  <= IDX_LEN_LO;
                node_ok_ff <= 1'b1;
            end else if (rx_take) begin
                rx_cnt_ff <= rx_cnt_ff + 16'h1;
                if (rx_cnt_ff == IDX_LEN_LO) len_ff[7:0] <= rx_byte;
                if (rx_cnt_ff == IDX_LEN_HI) begin
                    len_ff[15:8] <= rx_byte;
                    if ({rx_byte, len_ff[7:0]} < FRAME_OVH) rx_on_ff <= 1'b0;
                end
                if ((rx_cnt_ff == IDX_NODE_LO || rx_cnt_ff == IDX_NODE_HI)
                    && rx_byte != 8'h00) node_ok_ff <= 1'b0;
                if (rx_cnt_ff == IDX_FLAGS) flags_ff <= rx_byte;
                if (rx_cnt_ff == IDX_CMD) cmd_ff <= rx_byte;
                if (rx_cnt_ff >= IDX_DATA && rx_cnt_ff + 16'h2 < len_ff
                    && rx_off < 16'(RX_MAX)) rxd_ff[rx_off[RXW-1:0]] <= rx_byte;
                if (rx_cnt_ff > IDX_LEN_HI && rx_cnt_ff + 16'h2 == len_ff)
                    chk_lo_ff <= rx_byte;
                if (rx_cnt_ff > IDX_LEN_HI && rx_cnt_ff + 16'h1 == len_ff) begin
                    rx_on_ff <= 1'b0;
                    if (chk_lo_ff == rx_xor && rx_byte == ~rx_xor && node_ok_ff)
                        go_ff <= 1'b1;
                    else
                        drop_ff <= 1'b1;
                end
            end
        end
    end

    // transponder command decode
    always_comb begin
        dec_op  = OP_READ;
        dec_tag = 1'b1;
        unique case (cmd_ff)
            CMD_READ:    dec_op = OP_READ;
            CMD_WRITE:   dec_op = OP_WRITE;
            CMD_LOCK:    dec_op = OP_LOCK;
            CMD_DETAILS: dec_op = OP_DETAILS;
            CMD_BITMAP:  dec_op = OP_SID;
            default:     dec_tag = 1'b0;
        endcase
    end

    // result bytes of one finished transponder operation
    always_comb begin
        for (int i = 0; i < 9; i++) chunk[i] = 8'h00;
        chunk_n = N_ACK;
        unique case (tag_op_ff)
            OP_READ: begin
                {chunk[3], chunk[2], chunk[1], chunk[0]} = tag_rdata;
                chunk[4] = {6'h00, tag_lock};
                chunk[5] = tag_block_ff;
                chunk_n  = N_READ;
            end
            OP_WRITE, OP_LOCK: begin
                chunk[0] = RSP_OK;
                chunk_n  = N_ACK;
            end
            OP_DETAILS: begin
                {chunk[3], chunk[2], chunk[1], chunk[0]} = tag_uid;
                chunk[4] = tag_mfr;
                {chunk[6], chunk[5]} = tag_ver;
                chunk[7] = tag_nblk;
                chunk[8] = tag_bpb;
                chunk_n  = N_DETAILS;
            end
            OP_SID: begin
                {chunk[3], chunk[2], chunk[1], chunk[0]} = tag_uid;
                chunk_n  = N_SID;
            end
            default: chunk_n = N_ACK;
        endcase
    end

    // command execution and response assembly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff            <= ST_IDLE;
            tag_req_ff       <= 1'b0;
            tag_op_ff        <= OP_READ;
            tag_addressed_ff <= 1'b0;
            tag_addr_ff      <= 32'h0000_0000;
            tag_block_ff     <= 8'h00;
            tag_wdata_ff     <= 32'h0000_0000;
            loader_go_ff     <= 1'b0;
            misc_strobe_ff   <= 1'b0;
            misc_cmd_ff      <= 8'h00;
            misc_data_ff     <= 8'h00;
            rsp_cnt_ff       <= 8'h00;
            rsp_flags_ff     <= 8'h00;
            bmp_mode_ff      <= 1'b0;
            bmp_ff           <= 8'h00;
            bit_ff           <= 8'h00;
            for (int i = 0; i < RSP_MAX; i++) rsp_ff[i] <= 8'h00;
        end else begin
            tag_req_ff     <= 1'b0;
            loader_go_ff   <= 1'b0;
            misc_strobe_ff <= 1'b0;
            unique case (st_ff)
                ST_IDLE: if (go_ff) begin
                    rsp_cnt_ff       <= 8'h01;
                    rsp_flags_ff     <= 8'h00;
                    bmp_mode_ff      <= 1'b0;
                    rsp_ff[0]        <= RSP_OK;
                    tag_addr_ff      <= {rxd_ff[3], rxd_ff[2], rxd_ff[1], rxd_ff[0]};
                    tag_addressed_ff <= ads;
                    tag_block_ff     <= ads ? rxd_ff[4] : rxd_ff[0];
                    tag_wdata_ff     <= ads ? {rxd_ff[8], rxd_ff[7], rxd_ff[6], rxd_ff[5]}
                                            : {rxd_ff[4], rxd_ff[3], rxd_ff[2], rxd_ff[1]};
                    if (dec_tag) begin
                        rsp_cnt_ff  <= 8'h00;
                        tag_op_ff   <= dec_op;
                        tag_req_ff  <= 1'b1;
                        bmp_mode_ff <= cmd_ff == CMD_BITMAP;
                        bmp_ff      <= rxd_ff[0];
                        bit_ff      <= 8'h00;
                        st_ff       <= ST_WAIT;
                    end else if (cmd_ff == CMD_LOADER) begin
                        loader_go_ff <= 1'b1;
                        st_ff        <= ST_TX;
                    end else if (cmd_ff == CMD_FLASH || cmd_ff == CMD_VERSION
                                 || cmd_ff == CMD_INPUTS || cmd_ff == CMD_OUTPUTS
                                 || cmd_ff == CMD_CARRIER || cmd_ff == CMD_BAUD) begin
                        misc_strobe_ff <= 1'b1;
                        misc_cmd_ff    <= cmd_ff;
                        misc_data_ff   <= rxd_ff[0];
                        st_ff          <= ST_TX;
                    end else begin
                        rsp_flags_ff[FLAG_ERR_BIT] <= 1'b1;
                        rsp_ff[0]                  <= ERR_UNKNOWN;
                        st_ff                      <= ST_TX;
                    end
                end
                ST_WAIT: if (tag_done) begin
                    if (tag_err) begin
                        rsp_flags_ff[FLAG_ERR_BIT] <= 1'b1;
                        rsp_ff[0]                  <= tag_err_code;
                        rsp_cnt_ff                 <= 8'h01;
                        st_ff                      <= ST_TX;
                    end else begin
                        for (int i = 0; i < RSP_MAX; i++) begin
                            if (i >= int'(rsp_cnt_ff) && i < int'(rsp_cnt_ff) + int'(chunk_n))
                                rsp_ff[i] <= chunk[4'(i - int'(rsp_cnt_ff))];
                        end
                        rsp_cnt_ff <= rsp_cnt_ff + {4'h0, chunk_n};
                        if (tag_op_ff == OP_SID) tag_addr_ff <= tag_uid;
                        st_ff <= bmp_mode_ff ? ST_NEXT : ST_TX;
                    end
                end
                ST_NEXT: begin
                    if (bmp_ff == 8'h00) begin
                        st_ff <= ST_TX;
                    end else begin
                        bmp_ff <= bmp_ff >> 1;
                        bit_ff <= bit_ff + 8'h01;
                        if (bmp_ff[0]) begin
                            tag_op_ff        <= OP_READ;
                            tag_addressed_ff <= 1'b1;
                            tag_block_ff     <= bit_ff;
                            tag_req_ff       <= 1'b1;
                            st_ff            <= ST_WAIT;
                        end
                    end
                end
                ST_TX: if (tx_idx_ff == tx_len && (!tx_valid_ff || tx_ready))
                    st_ff <= ST_IDLE;
            endcase
        end
    end

    // response byte at the current frame position
    always_comb begin
        tx_next = 8'h00;
        if (tx_idx_ff == IDX_SOF) tx_next = SOF;
        else if (tx_idx_ff == IDX_LEN_LO) tx_next = tx_len[7:0];
        else if (tx_idx_ff == IDX_LEN_HI) tx_next = tx_len[15:8];
        else if (tx_idx_ff == IDX_FLAGS) tx_next = rsp_flags_ff;
        else if (tx_idx_ff == IDX_CMD) tx_next = cmd_ff;
        else if (tx_idx_ff + 16'h2 == tx_len) tx_next = tx_xor;
        else if (tx_idx_ff + 16'h1 == tx_len) tx_next = ~tx_xor;
        else if (tx_idx_ff >= IDX_DATA) tx_next = rsp_ff[tx_off[RSPW-1:0]];
    end

    // response byte stream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_idx_ff   <= 16'h0000;
            tx_byte_ff  <= 8'h00;
            tx_valid_ff <= 1'b0;
        end else if (st_ff != ST_TX) begin
            tx_idx_ff <= 16'h0000;
        end else if (tx_load) begin
            tx_byte_ff  <= tx_next;
            tx_valid_ff <= 1'b1;
            tx_idx_ff   <= tx_idx_ff + 16'h1;
        end else if (tx_ready) begin
            tx_valid_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_go_addr_read;
        st_ff == ST_IDLE && go_ff && flags_ff[FLAG_ADDR_BIT] && cmd_ff == CMD_READ;
    endsequence
    sequence s_go_bitmap;
        st_ff == ST_IDLE && go_ff && cmd_ff == CMD_BITMAP;
    endsequence

    drop_no_exec_a: assert property (drop_ff |-> !go_ff ##1 st_ff == ST_IDLE)
        else $error("dropped frame started a command");
    addr_read_a: assert property (s_go_addr_read |=> tag_req_ff && tag_addressed_ff
        && tag_op_ff == OP_READ) else $error("addressed read not issued addressed");
    err_flag_a: assert property (st_ff == ST_WAIT && tag_done && tag_err |=>
        rsp_flags_ff == 8'h10 && rsp_cnt_ff == 8'h01) else $error("error answer malformed");
    tx_sof_a: assert property (tx_load && tx_idx_ff == IDX_SOF |=>
        tx_byte_ff == SOF ##0 tx_valid_ff) else $error("response does not open with sof");
    tx_check_a: assert property (tx_load && tx_idx_ff + 16'h1 == tx_len |=>
        tx_byte_ff == ~tx_xor) else $error("check high byte not complement");
    cmd_echo_a: assert property (tx_load && tx_idx_ff == IDX_CMD |=>
        tx_byte_ff == cmd_ff) else $error("command code not echoed");
    loader_ok_a: assert property (st_ff == ST_IDLE && go_ff && cmd_ff == CMD_LOADER |=>
        loader_go_ff && st_ff == ST_TX && rsp_ff[0] == RSP_OK) else $error("loader entry wrong");
    bitmap_sid_a: assert property (s_go_bitmap |=> tag_req_ff && tag_op_ff == OP_SID
        && !tag_addressed_ff) else $error("bitmap read did not fetch identifier first");
    bitmap_blk_a: assert property (st_ff == ST_NEXT && bmp_ff[0] |=> tag_req_ff
        && tag_addressed_ff && tag_block_ff == $past(bit_ff)) else $error("bitmap block read wrong");
endmodule : rpd_decoder

// ### hdl/rpd_pkg.sv
/*
 * constants, codes and types of the host packet decoder.
 * assumes bytes arrive and leave through a byte-wide serial engine on the same clock.
 */
// What this block does
// - addressed flag set: command acts only on transponder with the given address.
// - failure sets response flag bit 4, data holds error code, other bits zero.
// - each packet ends with a 16-bit check word over all preceding bytes.
// - check low byte is xor of covered bytes, high byte its complement.
// - decode transponder codes 02h, 03h, 04h, 05h and 0fh.
// - block read data: optional address lsb first, then block number.
// - block read answer: data lsb first, lock-status byte, block-address byte.
// - write data: optional address, block number, data; success answers 00h.
// - lock data: optional address, block number; success answers 00h.
// - details answer: address 4, maker 1, version 2, blocks 1, bytes-per-block 1.
// - bitmap read is unaddressed; bit n selects block n; zero returns identifier only.
// - bitmap read fetches serial identifier first, then addressed reads with it.
// - bitmap answer: identifier, then per selected block data, lock, address ascending.
// - decode misc codes d0h, d8h, f0h, f1h, f2h, f4h, ffh.
// - loader entry hands control to loader and answers 00h.
// - response reuses frame layout, echoes command, data replaced by result.
// - frame: 01h, length lsb first counting all bytes, node address zero.
package rpd_pkg;
    localparam logic [7:0]  SOF           = 8'h01;
    localparam logic [7:0]  RSP_OK        = 8'h00;
    localparam logic [7:0]  ERR_UNKNOWN   = 8'h01;  // arbitrary code for an unknown command
    localparam int          FLAG_ADDR_BIT = 4;
    localparam int          FLAG_ERR_BIT  = 4;
    localparam logic [15:0] IDX_SOF       = 16'h0000;
    localparam logic [15:0] IDX_LEN_LO    = 16'h0001;
    localparam logic [15:0] IDX_LEN_HI    = 16'h0002;
    localparam logic [15:0] IDX_NODE_LO   = 16'h0003;
    localparam logic [15:0] IDX_NODE_HI   = 16'h0004;
    localparam logic [15:0] IDX_FLAGS     = 16'h0005;
    localparam logic [15:0] IDX_CMD       = 16'h0006;
    localparam logic [15:0] IDX_DATA      = 16'h0007;
    localparam logic [15:0] FRAME_OVH     = 16'h0009;
    localparam logic [7:0]  CMD_READ      = 8'h02;
    localparam logic [7:0]  CMD_WRITE     = 8'h03;
    localparam logic [7:0]  CMD_LOCK      = 8'h04;
    localparam logic [7:0]  CMD_DETAILS   = 8'h05;
    localparam logic [7:0]  CMD_BITMAP    = 8'h0f;
    localparam logic [7:0]  CMD_LOADER    = 8'hd0;
    localparam logic [7:0]  CMD_FLASH     = 8'hd8;
    localparam logic [7:0]  CMD_VERSION   = 8'hf0;
    localparam logic [7:0]  CMD_INPUTS    = 8'hf1;
    localparam logic [7:0]  CMD_OUTPUTS   = 8'hf2;
    localparam logic [7:0]  CMD_CARRIER   = 8'hf4;
    localparam logic [7:0]  CMD_BAUD      = 8'hff;
    localparam logic [3:0]  N_READ        = 4'h6;
    localparam logic [3:0]  N_ACK         = 4'h1;
    localparam logic [3:0]  N_DETAILS     = 4'h9;
    localparam logic [3:0]  N_SID         = 4'h4;

    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_LOCK    = 3'h2,
        OP_DETAILS = 3'h3,
        OP_SID     = 3'h4
    } rpd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_NEXT = 2'b11,
        ST_TX   = 2'b10
    } rpd_state_t;
endpackage : rpd_pkg

// ### hdl/rpd_check_acc.sv
/*
 * running xor of a byte stream, cleared at the start of each frame.
 * assumes clr and en come from logic on the same clock.
 */
`timescale 1ns/1ps
module rpd_check_acc (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       en,
    input  wire logic [7:0] byte_in,
    output logic      [7:0] lrc_ff
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lrc_ff <= 8'h00;
        end else if (clr || en) begin
            lrc_ff <= (clr ? 8'h00 : lrc_ff) ^ (en ? byte_in : 8'h00);
        end
    end
endmodule : rpd_check_acc

// ### sim/rpd_tag_model.sv
/*
 * transponder engine model: answers each request after DLY cycles.
 * assumes req is a one-cycle pulse on clk and blk holds until the next op.
 */
`timescale 1ns/1ps
module rpd_tag_model #(
    parameter int DLY = 3
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic [7:0]  blk,
    output logic             done,
    output logic      [31:0] rdata,
    output logic      [1:0]  lock,
    output logic      [31:0] uid,
    output logic      [39:0] det
);
    int cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 0;
            done <= 1'b0;
        end else begin
            done <= (cnt == 1);
            cnt  <= req ? DLY : (cnt != 0 ? cnt - 1 : 0);
        end
    end
    // results are only meaningful beside done; garbage otherwise
    assign rdata = done ? 32'h00112233 + 32'(blk) : ~(32'h00112233 + 32'(blk));
    assign lock  = done ? blk[1:0] : ~blk[1:0];
    assign uid   = done ? 32'h00104f23 : 32'hffefb0dc;
    assign det   = done ? 40'h0100050804 : 40'hfefffaf7fb;
endmodule : rpd_tag_model

// ### sim/rpd_decoder_test.sv
/*
 * self-checking bench of the packet decoder: table of commands, then hand cases.
 * assumes the transponder engine model beside the design.
 */
`timescale 1ns/1ps
module rpd_decoder_test;
    import rpd_pkg::*;
    typedef struct {logic [159:0] rq; int nq; logic [159:0] rs; int ns; logic [32:0] adr;} rpd_row_t;
    logic clk, rst, rx_valid, tx_ready, tag_err, done, tx_valid_ff, tag_req_ff, tag_addressed_ff;
    logic loader_go_ff, misc_strobe_ff, drop_ff;
    logic [7:0] rx_byte, tx_byte_ff, tag_block_ff, misc_cmd_ff, misc_data_ff;
    logic [31:0] tag_addr_ff, tag_wdata_ff, rdata, uid;
    logic [1:0] lock;
    logic [39:0] det;
    logic [32:0] exp_adr;
    rpd_op_t tag_op_ff, last_op;
    rpd_op_t op_exp[8] = '{OP_READ, OP_READ, OP_WRITE, OP_LOCK, OP_DETAILS, OP_READ, OP_SID, OP_SID};
    int miscompares, samples_checked, nreq, nload, nmisc, w;
    logic [7:0] q[$];
    logic [7:0] mc[7] = '{8'hd0, 8'hd8, 8'hf0, 8'hf1, 8'hf2, 8'hf4, 8'hff};
    rpd_row_t rows[8] = '{ // flag bits other than 4 stay zero
        '{160'h000201, 3, 160'h0002342211000101, 8, 33'h0},
        '{160'h1002d5a4340103, 7, 160'h0002362211000303, 8, {1'b1, 32'h0134a4d5}},
        '{160'h00030467452301, 7, 160'h000300, 3, 33'h0},
        '{160'h1004a434010004, 7, 160'h000400, 3, {1'b1, 32'h000134a4}},
        '{160'h0005, 2, 160'h0005234f10000105000804, 11, 33'h0},
        '{160'h000f09, 3, 160'h000f234f1000332211000000362211000303, 18, {1'b1, 32'h00104f23}},
        '{160'h000f00, 3, 160'h000f234f1000, 6, 33'h0},
        '{160'h007700, 3, 160'h107701, 3, 33'h0}};
    rpd_decoder dut_u (.clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_byte_ff(tx_byte_ff), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready),
        .tag_req_ff(tag_req_ff), .tag_op_ff(tag_op_ff), .tag_addressed_ff(tag_addressed_ff),
        .tag_addr_ff(tag_addr_ff), .tag_block_ff(tag_block_ff), .tag_wdata_ff(tag_wdata_ff),
        .tag_done(done), .tag_err(tag_err), .tag_err_code(8'h42), .tag_rdata(rdata),
        .tag_lock(lock), .tag_uid(uid), .tag_mfr(det[39:32]), .tag_ver(det[31:16]),
        .tag_nblk(det[15:8]), .tag_bpb(det[7:0]), .loader_go_ff(loader_go_ff),
        .misc_strobe_ff(misc_strobe_ff), .misc_cmd_ff(misc_cmd_ff),
        .misc_data_ff(misc_data_ff), .drop_ff(drop_ff));
    rpd_tag_model tag_u (.clk(clk), .rst(rst), .req(tag_req_ff), .blk(tag_block_ff),
        .done(done), .rdata(rdata), .lock(lock), .uid(uid), .det(det));
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic build(output logic [7:0] f[$], input logic [159:0] v, input int n);
        logic [7:0] x;
        f = {8'h01, 8'(n + 7), 8'h00, 8'h00, 8'h00};
        for (int i = n - 1; i >= 0; i--) f.push_back(v[8*i +: 8]);
        x = 8'h00;
        foreach (f[i]) x ^= f[i];
        f.push_back(x);
        f.push_back(~x);
    endtask : build
    task automatic send(logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge clk); #1;
            rx_byte = f[i];
            rx_valid = 1'b1;
        end
        @(posedge clk); #1;
        rx_valid = 1'b0;
    endtask : send
    task automatic run(logic [159:0] rq, int nq, logic [159:0] rs, int ns);
        logic [7:0] e[$];
        build(q, rq, nq);
        build(e, rs, ns);
        send(q);
        foreach (e[i]) begin // whole response awaited before the next request
            w = 0;
            do begin @(posedge clk); #1; w++; end while (tx_valid_ff !== 1'b1 && w < 400);
            chk(tx_byte_ff, e[i]);
        end
        @(posedge clk); #1;
        chk(tx_valid_ff, 0);
    endtask : run
    always @(posedge clk) begin
        nreq += (tag_req_ff === 1'b1);
        nload += (loader_go_ff === 1'b1);
        nmisc += (misc_strobe_ff === 1'b1);
        if (tag_req_ff === 1'b1) last_op = tag_op_ff;
        if (tag_req_ff === 1'b1 && tag_op_ff === OP_WRITE)
            chk(tag_wdata_ff, 32'h01234567);
        if (tag_req_ff === 1'b1 && tag_op_ff !== OP_SID) begin
            chk(tag_addressed_ff, exp_adr[32]);
            if (exp_adr[32]) chk(tag_addr_ff, exp_adr[31:0]);
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
    initial begin
        {rst, rx_valid, rx_byte, tx_ready, tag_err, exp_adr} = {1'b1, 44'h0};
        {miscompares, samples_checked, nreq, nload, nmisc} = '0;
        repeat (8) @(posedge clk); #1;
        rst = 1'b0;
        tx_ready = 1'b1;
        chk({tx_valid_ff, tag_req_ff, drop_ff, loader_go_ff, misc_strobe_ff}, 0);
        foreach (rows[i]) begin
            exp_adr = rows[i].adr;
            run(rows[i].rq, rows[i].nq, rows[i].rs, rows[i].ns);
            chk(last_op, op_exp[i]);
        end
        exp_adr = 33'h0;
        foreach (mc[i]) begin
            run({8'h00, mc[i], 8'h5a}, 3, {8'h00, mc[i], 8'h00}, 3);
            chk({misc_cmd_ff, misc_data_ff}, (i == 0) ? 16'h0000 : {mc[i], 8'h5a});
        end
        chk(nload, 1);
        chk(nmisc, 6);
        tag_err = 1'b1;
        run(160'h000201, 3, 160'h100242, 3);
        tag_err = 1'b0;
        w = nreq;
        for (int k = 0; k < 2; k++) begin // bad check word, then nonzero node address
            build(q, 160'h000201, 3);
            q[9] ^= 8'h01;
            if (k == 1) begin
                q[3] = 8'h01;
                q[8] ^= 8'h01;
            end
            send(q);
            chk(drop_ff, 1);
            repeat (30) @(posedge clk);
            chk({tx_valid_ff, 8'(nreq - w)}, 0);
        end
        // reset in the middle of a command, then a clean exchange
        build(q, 160'h000201, 3);
        send(q);
        repeat (2) @(posedge clk); #1;
        rst = 1'b1;
        @(posedge clk); #1;
        rst = 1'b0;
        chk({tx_valid_ff, tag_req_ff, drop_ff, loader_go_ff, misc_strobe_ff}, 0);
        run(160'h000201, 3, 160'h0002342211000101, 8);
        summarize();
    end
endmodule : rpd_decoder_test
